// *** rtl/bid_pkg.sv ***
// constants, types and field layout of the instruction decoder core
// Notes on behaviour
// - every instruction is one 12-bit word
// - destination bit 0 selects accumulator, 1 file
// - bit field picks one of eight bits
// - literal is 8 bits, jump target 9 bits
// - don't-care word bits are ignored, fill zero
// - one cycle; taken test or jump takes two
// - instruction cycle equals four clock periods
// - decrement, store, skip on zero, flags kept
// - increment, store, skip on zero, flags kept
// - register or with accumulator, zero flag only
// - register xor with accumulator, zero flag only
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - skip next when selected bit is low
// - skip next when selected bit is high
// - literal or into accumulator, zero flag only
// - literal to accumulator, pop stack, two cycles
// - literal xor into accumulator, zero flag only
// - standby enters power-down, updates sleep flags
// - call and program counter low writes clear bit eight; jump and return load all nine bits
// - port read-modify-write reads the pin levels
// - direction load copies accumulator to direction latches
// - timer zero write clears prescaler if assigned
package bid_pkg;

    localparam int INSTR_W = 12;
    localparam int PC_W = 9;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int STACK_DEPTH = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_FETCH = 2'h1;
    localparam logic [1:0] PHASE_READ = 2'h2;
    localparam logic [1:0] PHASE_EXEC = 2'h3;

    // file addresses handled inside the core or with side effects
    localparam logic [4:0] ADDR_TIMER_ZERO = 5'h01;
    localparam logic [4:0] ADDR_PC_LOW = 5'h02;
    localparam logic [4:0] ADDR_STATUS = 5'h03;
    localparam logic [4:0] ADDR_PORT = 5'h06;
    localparam logic [2:0] DIR_LOAD_PORT = 3'h6;

    // status and option bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF_CARRY = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SLEEP_ENTERED = 3;
    localparam int ST_WATCHDOG_EXPIRY = 4;
    localparam int OPT_PRESCALE_ASSIGN = 3;

    localparam logic [8:0] RESET_PC = 9'h000;
    localparam logic [7:0] RESET_DIR = 8'hff;
    localparam logic [7:0] RESET_OPTION = 8'hff;
    localparam logic [7:0] RESET_W = 8'h00;
    localparam logic [4:0] RESET_STATUS = 5'h18;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_OPTION_LOAD = 6'h01, OP_STANDBY = 6'h02,
        OP_WATCHDOG_CLEAR = 6'h03, OP_PIN_DIRECTION_LOAD = 6'h04, OP_MOVE_W_F = 6'h05,
        OP_CLEAR_W = 6'h06, OP_CLEAR_F = 6'h07, OP_SUB = 6'h08, OP_DEC = 6'h09,
        OP_REGISTER_OR = 6'h0a, OP_AND = 6'h0b, OP_REGISTER_XOR = 6'h0c, OP_ADD = 6'h0d,
        OP_MOVE_F = 6'h0e, OP_COMPLEMENT = 6'h0f, OP_INC = 6'h10,
        OP_DECREMENT_SKIP_ZERO = 6'h11, OP_ROTATE_RIGHT_CARRY = 6'h12,
        OP_ROTATE_LEFT_CARRY = 6'h13, OP_SWAP = 6'h14, OP_INCREMENT_SKIP_ZERO = 6'h15,
        OP_BIT_CLEAR = 6'h16, OP_BIT_SET = 6'h17, OP_SKIP_IF_BIT_LOW = 6'h18,
        OP_SKIP_IF_BIT_HIGH = 6'h19, OP_RETURN_WITH_LITERAL = 6'h1a, OP_CALL = 6'h1b,
        OP_ABSOLUTE_JUMP = 6'h1c, OP_MOVE_LITERAL = 6'h1d, OP_LITERAL_OR = 6'h1e,
        OP_LITERAL_AND = 6'h1f, OP_LITERAL_XOR = 6'h20
    } bid_op_e;

    typedef struct packed {
        logic [4:0] faddr;
        logic dest_file;
        logic [2:0] bit_num;
        logic [8:0] literal;
    } bid_fields_s;

endpackage

// *** rtl/bid_core.sv ***
// instruction decode and execute core with four-phase instruction cycle
`timescale 1ns/1ps
module bid_core #(
    parameter int STACK_LEVELS = 2
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [11:0] INSTR_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic [7:0] PIN_I,
    output logic [8:0] PMEM_ADDR_O,
    output logic [4:0] FILE_ADDR_O,
    output logic [7:0] FILE_WDATA_O,
    output logic FILE_WE_O,
    output logic [7:0] PIN_DIR_O,
    output logic [7:0] OPTION_O,
    output logic [7:0] STATUS_O,
    output logic [7:0] ACCUM_O,
    output logic SLEEP_O,
    output logic WATCHDOG_CLEAR_O,
    output logic PRESCALE_CLEAR_O
);
    import bid_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic bid_op_e decode_op(input logic [11:0] i);
        bid_op_e op;
        op = OP_NOP;
        casez (i)
            12'b0000_0000_0000: op = OP_NOP;
            12'b0000_0000_0010: op = OP_OPTION_LOAD;
            12'b0000_0000_0011: op = OP_STANDBY;
            12'b0000_0000_0100: op = OP_WATCHDOG_CLEAR;
            12'b0000_0000_0???: op = OP_PIN_DIRECTION_LOAD;
            12'b0000_001?_????: op = OP_MOVE_W_F;
            12'b0000_0100_0000: op = OP_CLEAR_W;
            12'b0000_011?_????: op = OP_CLEAR_F;
            12'b0000_10??_????: op = OP_SUB;
            12'b0000_11??_????: op = OP_DEC;
            12'b0001_00??_????: op = OP_REGISTER_OR;
            12'b0001_01??_????: op = OP_AND;
            12'b0001_10??_????: op = OP_REGISTER_XOR;
            12'b0001_11??_????: op = OP_ADD;
            12'b0010_00??_????: op = OP_MOVE_F;
            12'b0010_01??_????: op = OP_COMPLEMENT;
            12'b0010_10??_????: op = OP_INC;
            12'b0010_11??_????: op = OP_DECREMENT_SKIP_ZERO;
            12'b0011_00??_????: op = OP_ROTATE_RIGHT_CARRY;
            12'b0011_01??_????: op = OP_ROTATE_LEFT_CARRY;
            12'b0011_10??_????: op = OP_SWAP;
            12'b0011_11??_????: op = OP_INCREMENT_SKIP_ZERO;
            12'b0100_????_????: op = OP_BIT_CLEAR;
            12'b0101_????_????: op = OP_BIT_SET;
            12'b0110_????_????: op = OP_SKIP_IF_BIT_LOW;
            12'b0111_????_????: op = OP_SKIP_IF_BIT_HIGH;
            12'b1000_????_????: op = OP_RETURN_WITH_LITERAL;
            12'b1001_????_????: op = OP_CALL;
            12'b101?_????_????: op = OP_ABSOLUTE_JUMP;
            12'b1100_????_????: op = OP_MOVE_LITERAL;
            12'b1101_????_????: op = OP_LITERAL_OR;
            12'b1110_????_????: op = OP_LITERAL_AND;
            12'b1111_????_????: op = OP_LITERAL_XOR;
            default: op = OP_NOP;
        endcase
        return op;
    endfunction

    logic [1:0] phase_reg;
    logic [11:0] ir_reg;
    logic [7:0] fdata_reg;
    logic [8:0] pc_reg;
    logic [7:0] w_reg;
    logic [4:0] status_reg;
    logic [7:0] dir_reg;
    logic [7:0] option_reg;
    logic dead_reg;
    logic sleep_reg;
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    logic [8:0] stack_reg [STACK_LEVELS];
    bid_op_e op;
    bid_fields_s fld;
    logic exec;

    assign op = decode_op(ir_reg);
    // operand fields; bits outside the fields are never looked at
    assign fld = '{faddr: ir_reg[4:0], dest_file: ir_reg[5], bit_num: ir_reg[7:5],
                   literal: ir_reg[8:0]};
    assign exec = (phase_reg == PHASE_EXEC) && !dead_reg && !sleep_reg;

    // ----------------------------------------------------------------
    // phase counter and pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || sleep_reg)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    always_ff @(posedge CLK_I)
    begin
        pin_s1_reg <= PIN_I;
        pin_s2_reg <= pin_s1_reg;
    end

    // ----------------------------------------------------------------
    // fetch and operand read
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            ir_reg <= 12'h000;
            fdata_reg <= 8'h00;
        end
        else if (phase_reg == PHASE_FETCH)
            ir_reg <= INSTR_I;
        else if (phase_reg == PHASE_READ)
        begin
            case (fld.faddr)
                ADDR_PC_LOW: fdata_reg <= pc_reg[7:0];
                ADDR_STATUS: fdata_reg <= {3'h0, status_reg};
                ADDR_PORT: fdata_reg <= pin_s2_reg;
                default: fdata_reg <= FILE_RDATA_I;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // execute
    // ----------------------------------------------------------------
    logic [7:0] res;
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] bmask;
    logic wr_w, wr_f, upd_c, upd_dc, upd_z, skip, two_cyc;
    logic c_n, dc_n;
    logic [8:0] pc_next;
    logic [8:0] pc_inc;

    assign bmask = 8'h01 << fld.bit_num;
    assign pc_inc = pc_reg + 9'h001;

    always_comb
    begin
        res = 8'h00;
        sum = 9'h000;
        half = 5'h00;
        wr_w = 1'b0;
        wr_f = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        skip = 1'b0;
        c_n = status_reg[ST_CARRY];
        dc_n = status_reg[ST_HALF_CARRY];
        pc_next = pc_inc;
        case (op)
            OP_ADD, OP_SUB:
            begin
                sum = (op == OP_ADD) ? {1'b0, fdata_reg} + {1'b0, w_reg}
                                     : {1'b0, fdata_reg} + {1'b0, ~w_reg} + 9'h001;
                half = (op == OP_ADD) ? {1'b0, fdata_reg[3:0]} + {1'b0, w_reg[3:0]}
                                      : {1'b0, fdata_reg[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;
                res = sum[7:0];
                c_n = sum[8];
                dc_n = half[4];
                {upd_c, upd_dc, upd_z} = 3'b111;
            end
            OP_AND: res = w_reg & fdata_reg;
            OP_REGISTER_OR: res = w_reg | fdata_reg;
            OP_REGISTER_XOR: res = w_reg ^ fdata_reg;
            OP_MOVE_F: res = fdata_reg;
            OP_COMPLEMENT: res = ~fdata_reg;
            OP_INC, OP_INCREMENT_SKIP_ZERO: res = fdata_reg + 8'h01;
            OP_DEC, OP_DECREMENT_SKIP_ZERO: res = fdata_reg - 8'h01;
            OP_SWAP: res = {fdata_reg[3:0], fdata_reg[7:4]};
            OP_ROTATE_LEFT_CARRY:
            begin
                res = {fdata_reg[6:0], status_reg[ST_CARRY]};
                c_n = fdata_reg[7];
                upd_c = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY:
            begin
                res = {status_reg[ST_CARRY], fdata_reg[7:1]};
                c_n = fdata_reg[0];
                upd_c = 1'b1;
            end
            OP_BIT_CLEAR: res = fdata_reg & ~bmask;
            OP_BIT_SET: res = fdata_reg | bmask;
            OP_SKIP_IF_BIT_LOW: skip = (fdata_reg & bmask) == 8'h00;
            OP_SKIP_IF_BIT_HIGH: skip = (fdata_reg & bmask) != 8'h00;
            OP_MOVE_W_F: res = w_reg;
            OP_CLEAR_F, OP_CLEAR_W: res = 8'h00;
            OP_MOVE_LITERAL, OP_RETURN_WITH_LITERAL: res = fld.literal[7:0];
            OP_LITERAL_OR: res = w_reg | fld.literal[7:0];
            OP_LITERAL_AND: res = w_reg & fld.literal[7:0];
            OP_LITERAL_XOR: res = w_reg ^ fld.literal[7:0];
            OP_CALL: pc_next = {1'b0, fld.literal[7:0]};
            OP_ABSOLUTE_JUMP: pc_next = fld.literal;
            default: res = 8'h00;
        endcase
        case (op)
            OP_ADD, OP_SUB, OP_AND, OP_REGISTER_OR, OP_REGISTER_XOR, OP_MOVE_F,
            OP_COMPLEMENT, OP_INC, OP_DEC, OP_CLEAR_F, OP_CLEAR_W, OP_LITERAL_OR,
            OP_LITERAL_AND, OP_LITERAL_XOR:
                upd_z = 1'b1;
            default: upd_z = upd_z;
        endcase
        case (op)
            OP_ADD, OP_SUB, OP_AND, OP_REGISTER_OR, OP_REGISTER_XOR, OP_MOVE_F,
            OP_COMPLEMENT, OP_INC, OP_DEC, OP_SWAP, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO:
            begin
                wr_w = !fld.dest_file;
                wr_f = fld.dest_file;
            end
            OP_MOVE_W_F, OP_CLEAR_F, OP_BIT_CLEAR, OP_BIT_SET: wr_f = 1'b1;
            OP_CLEAR_W, OP_MOVE_LITERAL, OP_LITERAL_OR, OP_LITERAL_AND, OP_LITERAL_XOR,
            OP_RETURN_WITH_LITERAL:
                wr_w = 1'b1;
            default: wr_w = 1'b0;
        endcase
        if ((op == OP_INCREMENT_SKIP_ZERO || op == OP_DECREMENT_SKIP_ZERO) && res == 8'h00)
            skip = 1'b1;
        if (op == OP_RETURN_WITH_LITERAL)
            pc_next = stack_reg[0];
        if (skip)
            pc_next = pc_reg + 9'h002;
        if (wr_f && fld.faddr == ADDR_PC_LOW)
            pc_next = {1'b0, res};
    end

    assign two_cyc = skip || op == OP_CALL || op == OP_ABSOLUTE_JUMP
                     || op == OP_RETURN_WITH_LITERAL
                     || (wr_f && fld.faddr == ADDR_PC_LOW);

    // ----------------------------------------------------------------
    // architectural state
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pc_reg <= RESET_PC;
            dead_reg <= 1'b0;
        end
        else if (phase_reg == PHASE_EXEC)
        begin
            if (dead_reg)
                dead_reg <= 1'b0;
            else if (!sleep_reg)
            begin
                pc_reg <= pc_next;
                dead_reg <= two_cyc;
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            for (int s = 0; s < STACK_LEVELS; s++)
                stack_reg[s] <= RESET_PC;
        else if (exec && op == OP_CALL)
        begin
            stack_reg[0] <= pc_inc;
            for (int s = 1; s < STACK_LEVELS; s++)
                stack_reg[s] <= stack_reg[s - 1];
        end
        else if (exec && op == OP_RETURN_WITH_LITERAL)
            for (int s = 0; s < STACK_LEVELS - 1; s++)
                stack_reg[s] <= stack_reg[s + 1];
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            w_reg <= RESET_W;
        else if (exec && wr_w)
            w_reg <= res;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            status_reg <= RESET_STATUS;
        else if (exec)
        begin
            if (wr_f && fld.faddr == ADDR_STATUS)
                status_reg[2:0] <= res[2:0];
            if (upd_c)
                status_reg[ST_CARRY] <= c_n;
            if (upd_dc)
                status_reg[ST_HALF_CARRY] <= dc_n;
            if (upd_z)
                status_reg[ST_ZERO] <= (res == 8'h00);
            if (op == OP_STANDBY)
                status_reg[4:3] <= 2'b10;
            if (op == OP_WATCHDOG_CLEAR)
                status_reg[4:3] <= 2'b11;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            dir_reg <= RESET_DIR;
            option_reg <= RESET_OPTION;
            sleep_reg <= 1'b0;
        end
        else if (exec)
        begin
            if (op == OP_PIN_DIRECTION_LOAD && ir_reg[2:0] == DIR_LOAD_PORT)
                dir_reg <= w_reg;
            if (op == OP_OPTION_LOAD)
                option_reg <= w_reg;
            if (op == OP_STANDBY)
                sleep_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            FILE_ADDR_O <= 5'h00;
            FILE_WDATA_O <= 8'h00;
            FILE_WE_O <= 1'b0;
            WATCHDOG_CLEAR_O <= 1'b0;
            PRESCALE_CLEAR_O <= 1'b0;
        end
        else
        begin
            if (phase_reg == PHASE_FETCH)
                FILE_ADDR_O <= INSTR_I[4:0];
            FILE_WDATA_O <= res;
            FILE_WE_O <= exec && wr_f && fld.faddr != ADDR_PC_LOW
                         && fld.faddr != ADDR_STATUS;
            WATCHDOG_CLEAR_O <= exec && (op == OP_WATCHDOG_CLEAR || op == OP_STANDBY);
            PRESCALE_CLEAR_O <= exec && wr_f && fld.faddr == ADDR_TIMER_ZERO
                                && !option_reg[OPT_PRESCALE_ASSIGN];
        end
    end

    assign PMEM_ADDR_O = pc_reg;
    assign PIN_DIR_O = dir_reg;
    assign OPTION_O = option_reg;
    assign STATUS_O = {3'h0, status_reg};
    assign ACCUM_O = w_reg;
    assign SLEEP_O = sleep_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_exec_dead;
        exec && two_cyc ##1 dead_reg [*4];
    endsequence

    a_phase_four: assert property (@(posedge CLK_I) disable iff (SRST_I)
        phase_reg == PHASE_EXEC && !sleep_reg && !(exec && op == OP_STANDBY)
        |=> phase_reg == 2'h0 ##3 phase_reg == PHASE_EXEC)
        else $error("instruction cycle is not four clocks");
    a_two_cycle: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_exec_dead |=> !dead_reg && $stable(pc_reg))
        else $error("two-cycle instruction did not stall one cycle");
    a_dest_w: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_REGISTER_XOR && !fld.dest_file
        |=> w_reg == ($past(w_reg) ^ $past(fdata_reg)) && !FILE_WE_O)
        else $error("xor result not placed in accumulator");
    a_xor_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_REGISTER_XOR
        |=> STATUS_O[ST_ZERO] == (($past(w_reg) ^ $past(fdata_reg)) == 8'h00)
        && STATUS_O[ST_CARRY] == $past(status_reg[ST_CARRY]))
        else $error("register xor flag update wrong");
    a_decskip_flags: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_DECREMENT_SKIP_ZERO |=> status_reg == $past(status_reg)
        && dead_reg == ($past(fdata_reg) == 8'h01))
        else $error("decrement skip wrong");
    a_rotate_left: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_ROTATE_LEFT_CARRY |=> status_reg[ST_CARRY] == $past(fdata_reg[7])
        && status_reg[ST_ZERO] == $past(status_reg[ST_ZERO]))
        else $error("rotate left carry wrong");
    a_bit_skip: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_SKIP_IF_BIT_LOW && fdata_reg[fld.bit_num] == 1'b0
        |=> dead_reg && pc_reg == $past(pc_reg) + 9'h002 && !FILE_WE_O)
        else $error("skip on low bit failed");
    a_call_bit8: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_CALL |=> pc_reg[8] == 1'b0 && stack_reg[0] == $past(pc_inc))
        else $error("call did not clear bit eight");
    a_return_lit: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_RETURN_WITH_LITERAL |=> pc_reg == $past(stack_reg[0])
        && w_reg == $past(fld.literal[7:0]) && dead_reg)
        else $error("return with literal wrong");
    a_standby: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_STANDBY |=> SLEEP_O && status_reg[4:3] == 2'b10)
        else $error("standby flags wrong");
    a_dir_load: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && op == OP_PIN_DIRECTION_LOAD && ir_reg[2:0] == DIR_LOAD_PORT
        |=> PIN_DIR_O == $past(w_reg))
        else $error("direction latches not loaded");
    a_prescale_clr: assert property (@(posedge CLK_I) disable iff (SRST_I)
        exec && wr_f && fld.faddr == ADDR_TIMER_ZERO && !option_reg[OPT_PRESCALE_ASSIGN]
        |=> PRESCALE_CLEAR_O && FILE_WE_O)
        else $error("prescaler not cleared on timer write");
    a_port_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
        phase_reg == PHASE_READ && fld.faddr == ADDR_PORT |=> fdata_reg == $past(pin_s2_reg))
        else $error("port operand not taken from pin levels");

endmodule

// *** bench/bid_mem.sv ***
// program memory and file register model facing the decoder core
`timescale 1ns/1ps
module bid_mem (
    input wire logic clk_i,
    input wire logic [8:0] pmem_addr_i,
    input wire logic [4:0] file_addr_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic file_we_i,
    output logic [11:0] instr_o,
    output logic [7:0] file_rdata_o
);
    logic [11:0] rom [0:511];
    logic [7:0] ram [0:31];
    assign instr_o = rom[pmem_addr_i];
    assign file_rdata_o = ram[file_addr_i];
    always @(posedge clk_i)
    begin
        if (file_we_i)
        begin
            ram[file_addr_i] <= file_wdata_i;
        end
    end
endmodule

// *** bench/baseline_instruction_decoder_tb.sv ***
// self-checking bench running a short program through the decoder core
`timescale 1ns/1ps
module baseline_instruction_decoder_tb;
    import bid_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] pins = 8'h00;
    logic [11:0] instr;
    logic [7:0] rdata, wdata, pin_dir, status, accum, option;
    logic [8:0] pmem_addr;
    logic [4:0] faddr;
    logic we, sleep, wdc, pre;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int pre_cnt = 0;
    int wdc_cnt = 0;
    integer seed = 32'hbaca395e;

    always #5 clk = ~clk;

    bid_core bid_core_inst (.CLK_I(clk), .SRST_I(srst), .INSTR_I(instr), .FILE_RDATA_I(rdata),
        .PIN_I(pins), .PMEM_ADDR_O(pmem_addr), .FILE_ADDR_O(faddr), .FILE_WDATA_O(wdata),
        .FILE_WE_O(we), .PIN_DIR_O(pin_dir), .OPTION_O(option), .STATUS_O(status),
        .ACCUM_O(accum), .SLEEP_O(sleep), .WATCHDOG_CLEAR_O(wdc), .PRESCALE_CLEAR_O(pre));

    bid_mem bid_mem_inst (.clk_i(clk), .pmem_addr_i(pmem_addr), .file_addr_i(faddr),
        .file_wdata_i(wdata), .file_we_i(we), .instr_o(instr), .file_rdata_o(rdata));

    task automatic report_and_stop();
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ceiling well above four runs of about 150 cycles each
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    always @(posedge clk)
    begin
        #1 pins = $random(seed);
        // one-cycle pulses, each seen once while it stands
        if (pre === 1'b1)
            pre_cnt++;
        if (wdc === 1'b1)
            wdc_cnt++;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic run_once();
        logic [7:0] a, b, k, r, s, t, v, o;
        logic [2:0] n, m;
        logic [11:0] prog [0:33];
        int c;
        a = $random(seed);
        b = $random(seed);
        k = $random(seed);
        r = $random(seed);
        t = $random(seed);
        // option value with the prescaler assigned to the timer
        o = $random(seed) & 8'hf7;
        n = $random(seed);
        m = $random(seed);
        // half the runs force a zero literal result
        s = ($random(seed) & 1) ? (k | r) : $random(seed);
        v = a | b;
        prog = '{{4'hc, a}, 12'h006, 12'h030, {4'hc, b}, 12'h130, 12'h190, 12'h031, {4'hc, o},
            12'h002, 12'h021, 12'hc01, 12'h023, 12'h370, 12'h310, 12'h032, 12'hc01, 12'h033,
            12'h2f3, 12'hcee, 12'hcff, 12'h034, 12'h3d4, 12'hcee, {4'h6, n, 5'h13}, 12'h2b3,
            {4'h7, m, 5'h13}, {4'hc, k}, {4'hd, r}, {4'hf, s}, 12'h036, 12'h921, 12'h035,
            12'h003, {4'h8, t}};
        @(posedge clk);
        #1 srst = 1'b1;
        for (int i = 0; i < 512; i++)
            bid_mem_inst.rom[i] = (i < 34) ? prog[i] : 12'h000;
        for (int i = 0; i < 32; i++)
            bid_mem_inst.ram[i] = $random(seed);
        pre_cnt = 0;
        wdc_cnt = 0;
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        c = 0;
        while (pmem_addr === 9'h000 && c < 100)
        begin
            @(posedge clk);
            #1 c++;
        end
        c = 0;
        while (pmem_addr !== 9'h020 && c < 400)
        begin
            @(posedge clk);
            #1 c++;
        end
        // 29 instructions and 5 dead cycles of 4 clocks after the first, up to address 32
        check(c[8:0], 9'd136, "cycle count");
        c = 0;
        while (sleep !== 1'b1 && c < 40)
        begin
            @(posedge clk);
            #1 c++;
        end
        // let the pulse counter settle in this time step
        #2;
        check({8'h00, sleep}, 9'h001, "standby");
        check({1'b0, status}, {4'h0, 2'b10, s == (k | r), 2'b01}, "status");
        check({1'b0, accum}, {1'b0, t}, "accumulator");
        check({1'b0, bid_mem_inst.ram[5'h15]}, {1'b0, t}, "return");
        check({1'b0, bid_mem_inst.ram[5'h16]}, {1'b0, (k | r) ^ s}, "literal");
        check({1'b0, bid_mem_inst.ram[5'h10]}, {1'b0, v[6:0], 1'b1}, "rotl");
        check({1'b0, bid_mem_inst.ram[5'h11]}, {1'b0, v ^ b}, "xor");
        check({1'b0, bid_mem_inst.ram[5'h12]}, {1'b0, v}, "rotr");
        check({1'b0, bid_mem_inst.ram[5'h13]}, 9'h000, "decrement");
        check({1'b0, bid_mem_inst.ram[5'h14]}, 9'h0ff, "increment");
        check({1'b0, pin_dir}, {1'b0, a}, "direction");
        check({1'b0, option}, {1'b0, o}, "option");
        check({1'b0, bid_mem_inst.ram[5'h01]}, {1'b0, o}, "timer write");
        check(pre_cnt[8:0], 9'h001, "prescaler clear");
        check(wdc_cnt[8:0], 9'h001, "watchdog clear");
    endtask

    initial
    begin
        repeat (4) run_once();
        report_and_stop();
    end
endmodule
